/* File: core/rsp_port.sv */
`default_nettype none

module rsp_port (
  // System clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Serial pins
  input  wire logic                sclk,
  input  wire logic                ss_n,
  input  wire logic                mosi,
  output logic                     miso_out,
  output logic                     miso_oe_n,
  output logic                     miso_pulldown,
  // Configuration
  input  wire rsp_pkg::rsp_cfg_t   cfg,
  // Register write port
  output logic                     reg_wr_en,
  output rsp_pkg::rsp_reg_wr_t     reg_wr,
  input  wire logic                reg_writable,
  // Register read port
  output logic                     reg_rd_en,
  output logic [5:0]               reg_rd_addr,
  input  wire logic [7:0]          reg_rd_data,
  input  wire logic                reg_rd_exists,
  // FIFO port
  output logic                     fifo_push,
  output logic [7:0]               fifo_push_data,
  output logic                     fifo_pop,
  input  wire logic [7:0]          fifo_head,
  // Direct commands
  output logic                     cmd_start,
  output logic [5:0]               cmd_code_bits,
  input  wire logic                cmd_done,
  input  wire logic                irq_ack,
  output logic                     irq,
  // Status
  output logic                     link_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, falling edges: decode and capture

  rsp_pkg::rsp_state_t state;
  rsp_pkg::rsp_state_t next_state;
  logic [2:0]          bit_cnt;
  logic [6:0]          sh_in;
  logic [5:0]          ptr;
  logic [5:0]          next_ptr;

  wire [7:0] next_byte    = {sh_in, mosi};
  wire       byte_done    = (bit_cnt == rsp_pkg::BIT_LAST);
  wire [1:0] op_sel       = next_byte[7:6];
  wire       op_select_hi = op_sel[1];
  wire       op_select_lo = op_sel[0];
  wire [5:0] code_field   = next_byte[5:0];
  wire       in_mode      = (state == rsp_pkg::RSP_ST_MODE);
  wire       mode_done    = in_mode && byte_done;
  wire       is_rd_op     = (op_sel == rsp_pkg::OP_REG_READ);

  // commit on last bit; partial byte never fires
  wire wr_fire   = byte_done && (state == rsp_pkg::RSP_ST_WRITE);
  wire push_fire = byte_done && (state == rsp_pkg::RSP_ST_LOAD);
  // pop only once the byte is fully out
  wire pop_fire  = byte_done && (state == rsp_pkg::RSP_ST_UNLOAD);
  // command starts on last falling edge
  wire cmd_fire  = mode_done && op_select_hi && op_select_lo;
  // Read fetch issued a half period before its first bit is due
  wire rd_fire   = (mode_done && is_rd_op) ||
                   (byte_done && (state == rsp_pkg::RSP_ST_READ));
  wire [5:0] rd_addr_src = in_mode ? code_field : ptr;
  // head fetched on entry and after every pop
  wire unload_start = mode_done && (op_sel == rsp_pkg::OP_FIFO) &&
                      (code_field == rsp_pkg::FIFO_READ_CODE);
  wire head_fire    = unload_start || pop_fire;

  // first two bits pick the operation
  always_comb begin
    next_state = state;
    if (byte_done) begin
      case (state)
        rsp_pkg::RSP_ST_MODE: begin
          case (op_sel)
            rsp_pkg::OP_REG_WRITE: next_state = rsp_pkg::RSP_ST_WRITE;
            rsp_pkg::OP_REG_READ:  next_state = rsp_pkg::RSP_ST_READ;
            rsp_pkg::OP_FIFO: begin
              if (code_field == rsp_pkg::FIFO_LOAD_CODE)
                next_state = rsp_pkg::RSP_ST_LOAD;
              else if (code_field == rsp_pkg::FIFO_READ_CODE)
                next_state = rsp_pkg::RSP_ST_UNLOAD;
              else
                next_state = rsp_pkg::RSP_ST_IGNORE;
            end
            default: next_state = rsp_pkg::RSP_ST_MODE;
          endcase
        end
        default: next_state = state;
      endcase
    end
  end

  // address steps by one per data byte
  always_comb begin
    next_ptr = ptr;
    if (mode_done) begin
      next_ptr = is_rd_op ? 6'(code_field + 6'h01) : code_field;
    end else if (byte_done) begin
      next_ptr = 6'(ptr + 6'h01);
    end
  end

  // chip select high resets; sample on falling edge
  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      state   <= rsp_pkg::RSP_ST_MODE;
      bit_cnt <= rsp_pkg::BIT_FIRST;
      sh_in   <= 7'h00;
      ptr     <= rsp_pkg::ADDR_ZERO;
    end else begin
      state   <= next_state;
      bit_cnt <= 3'(bit_cnt + 3'h1);
      sh_in   <= next_byte[6:0];
      ptr     <= next_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain, rising edges: read data out

  logic [7:0] sh_out;
  logic [7:0] rd_hold;
  logic [7:0] fifo_head_q;

  wire in_unload = (state == rsp_pkg::RSP_ST_UNLOAD);
  wire load_out  = (bit_cnt == rsp_pkg::BIT_FIRST) &&
                   ((state == rsp_pkg::RSP_ST_READ) || in_unload);
  // Words settle within a few system clocks after the fetch event
  wire [7:0] out_src = in_unload ? fifo_head_q : rd_hold;

  // change on rising edge; drive only in read data
  always_ff @(posedge sclk or posedge ss_n) begin
    if (ss_n) begin
      sh_out    <= rsp_pkg::BYTE_ZERO;
      miso_oe_n <= 1'b1;
    end else if (load_out) begin
      sh_out    <= out_src;
      miso_oe_n <= 1'b0;
    end else begin
      sh_out    <= {sh_out[6:0], 1'b0};
    end
  end

  assign miso_out = sh_out[7];

  assign miso_pulldown = miso_oe_n &&
    (cfg.miso_pulldown_opt_a || cfg.miso_pulldown_opt_b);

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the system domain

  logic        wr_pulse;
  logic        rd_pulse;
  logic        push_pulse;
  logic        pop_pulse;
  logic        cmd_pulse;
  logic [13:0] wr_word;
  logic        pop_req;
  logic        head_take;
  logic        link_idle;

  rsp_evt_xfer #(.W(14)) u_wr (
    .src_clk   (sclk),
    .rst       (rst),
    .src_fire  (wr_fire),
    .src_data  ({ptr, next_byte}),
    .clk       (clk),
    .dst_pulse (wr_pulse),
    .dst_data  (wr_word)
  );

  rsp_evt_xfer #(.W(6)) u_rd (
    .src_clk   (sclk),
    .rst       (rst),
    .src_fire  (rd_fire),
    .src_data  (rd_addr_src),
    .clk       (clk),
    .dst_pulse (rd_pulse),
    .dst_data  (reg_rd_addr)
  );

  rsp_evt_xfer #(.W(8)) u_push (
    .src_clk   (sclk),
    .rst       (rst),
    .src_fire  (push_fire),
    .src_data  (next_byte),
    .clk       (clk),
    .dst_pulse (push_pulse),
    .dst_data  (fifo_push_data)
  );

  rsp_evt_xfer #(.W(1)) u_pop (
    .src_clk   (sclk),
    .rst       (rst),
    .src_fire  (head_fire),
    .src_data  (pop_fire),
    .clk       (clk),
    .dst_pulse (pop_pulse),
    .dst_data  (pop_req)
  );

  rsp_evt_xfer #(.W(6)) u_cmd (
    .src_clk   (sclk),
    .rst       (rst),
    .src_fire  (cmd_fire),
    .src_data  (code_field),
    .clk       (clk),
    .dst_pulse (cmd_pulse),
    .dst_data  (cmd_code_bits)
  );

  rsp_sync #(.RST_VAL(1'b1)) u_ss_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (ss_n),
    .sync_out (link_idle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System domain

  // FIFO traffic only when enabled and oscillator stable
  wire fifo_ok = cfg.fifo_enable && cfg.osc_stable;

  assign reg_wr = wr_word;
  assign reg_wr_en = wr_pulse && reg_writable;
  // Prefetch reads one address beyond the last byte the master takes
  assign reg_rd_en = rd_pulse;
  assign fifo_push = push_pulse && fifo_ok;
  assign fifo_pop  = pop_pulse && pop_req && fifo_ok;
  assign cmd_start = cmd_pulse;
  assign link_active = ~link_idle;

  wire [7:0] rd_value = reg_rd_exists ? reg_rd_data : rsp_pkg::BYTE_ZERO;
  // Head held still between fetches so the link side never sees it move
  wire [7:0] head_value = fifo_ok ? fifo_head : rsp_pkg::BYTE_ZERO;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_hold     <= rsp_pkg::BYTE_ZERO;
      fifo_head_q <= rsp_pkg::BYTE_ZERO;
      head_take   <= 1'b0;
    end else begin
      if (rd_pulse) begin
        rd_hold <= rd_value;
      end
      // Taken one clock after a pop, once the FIFO has moved on
      head_take <= pop_pulse;
      if (head_take) begin
        fifo_head_q <= head_value;
      end
    end
  end

  // finished command raises request; set beats acknowledge
  always_ff @(posedge clk) begin
    if (rst)
      irq <= 1'b0;
    else if (cmd_done)
      irq <= 1'b1;
    else if (irq_ack)
      irq <= 1'b0;
  end

endmodule : rsp_port

`default_nettype wire

/* File: core/rsp_pkg.sv */
// Behaviour
// - Chip select high holds the serial logic in reset; it runs only while low.
// - Serial input is sampled on each falling serial clock edge.
// - Transfers are bytes; the first two bits select the operation.
// - Mode 00 plus six-bit address writes; mode 01 plus address reads.
// - Every address, command and data byte travels most significant bit first.
// - Each further data byte of a read or write uses the next address.
// - Serial output floats except while read data is being shifted out.
// - While floating, a weak pull-down is on if either option bit is set.
// - Register access always allowed; FIFO only when enabled and oscillator stable.
// - A written byte commits on the falling edge of its last bit.
// - A write byte cut short by chip select rising is discarded.
// - Writes to missing or read-only registers are ignored.
// - Read data changes on rising edges; the master samples on falling edges.
// - Reading a missing register returns all zeros.
// - Mode 10 with code all zero loads every following byte into the FIFO.
// - A partial FIFO load byte is never stored.
// - Mode 10 with code all ones shifts FIFO bytes out on rising edges.
// - A FIFO byte not fully shifted out stays unread for next time.
// - Mode 11 plus six-bit code starts a command on the last falling edge.
// - A finished lasting command raises the interrupt request.
// - After an immediate command another operation may follow, chip select low.
// - The port is a slave only; events are reported on an interrupt output.
`default_nettype none

package rsp_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;

  // Operation select field
  localparam logic [1:0] OP_REG_WRITE = 2'h0;
  localparam logic [1:0] OP_REG_READ  = 2'h1;
  localparam logic [1:0] OP_FIFO      = 2'h2;
  localparam logic [1:0] OP_COMMAND   = 2'h3;

  // Code field of FIFO operations
  localparam logic [5:0] FIFO_LOAD_CODE = 6'h00;
  localparam logic [5:0] FIFO_READ_CODE = 6'h3f;

  // Bit counter within a byte
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Reset and idle values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] ADDR_ZERO = 6'h00;

  typedef enum logic [2:0] {
    RSP_ST_MODE,
    RSP_ST_WRITE,
    RSP_ST_READ,
    RSP_ST_LOAD,
    RSP_ST_UNLOAD,
    RSP_ST_IGNORE
  } rsp_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rsp_reg_wr_t;

  typedef struct packed {
    logic fifo_enable;
    logic osc_stable;
    logic miso_pulldown_opt_a;
    logic miso_pulldown_opt_b;
  } rsp_cfg_t;

endpackage : rsp_pkg

`default_nettype wire

/* File: core/rsp_sync.sv */
`default_nettype none

module rsp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // System clock
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : rsp_sync

`default_nettype wire

/* File: core/rsp_evt_xfer.sv */
`default_nettype none

module rsp_evt_xfer #(
  parameter int W = 8
) (
  // Source, falling link clock edges
  input  wire logic         src_clk,
  input  wire logic         rst,
  input  wire logic         src_fire,
  input  wire logic [W-1:0] src_data,
  // Destination, system clock
  input  wire logic         clk,
  output logic              dst_pulse,
  output logic [W-1:0]      dst_data
);

  logic         src_tgl;
  logic [W-1:0] src_hold;
  logic         tgl_s1;
  logic         tgl_s2;
  logic         tgl_s3;
  wire          tgl_edge = tgl_s2 ^ tgl_s3;

  // Toggle never reset by chip select, else a phantom event appears
  always_ff @(negedge src_clk or posedge rst) begin
    if (rst) begin
      src_tgl  <= 1'b0;
      src_hold <= '0;
    end else if (src_fire) begin
      src_tgl  <= ~src_tgl;
      src_hold <= src_data;
    end
  end

  // Hold is stable for a byte time, far longer than the sync delay
  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s1    <= 1'b0;
      tgl_s2    <= 1'b0;
      tgl_s3    <= 1'b0;
      dst_pulse <= 1'b0;
      dst_data  <= '0;
    end else begin
      tgl_s1    <= src_tgl;
      tgl_s2    <= tgl_s1;
      tgl_s3    <= tgl_s2;
      dst_pulse <= tgl_edge;
      if (tgl_edge) begin
        dst_data <= src_hold;
      end
    end
  end

endmodule : rsp_evt_xfer

`default_nettype wire

/* File: bench/rsp_port_monitor.sv */
`default_nettype none

module rsp_port_monitor (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Serial pins
  input wire logic              ss_n,
  input wire logic              miso_oe_n,
  input wire logic              miso_pulldown,
  input wire rsp_pkg::rsp_cfg_t cfg,
  // System side
  input wire logic              reg_wr_en,
  input wire logic              reg_writable,
  input wire logic              fifo_push,
  input wire logic              fifo_pop,
  input wire logic              cmd_start,
  input wire logic              cmd_done,
  input wire logic              irq_ack,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_float_deselected: assert property (ss_n |-> miso_oe_n)
    else $error("output driven while deselected");
  a_pulldown_level: assert property (miso_pulldown == (miso_oe_n &&
    (cfg.miso_pulldown_opt_a || cfg.miso_pulldown_opt_b)))
    else $error("pull-down level wrong");
  a_push_gated: assert property (fifo_push |->
    cfg.fifo_enable && cfg.osc_stable)
    else $error("push while fifo disabled");
  a_pop_gated: assert property (fifo_pop |->
    cfg.fifo_enable && cfg.osc_stable)
    else $error("pop while fifo disabled");
  a_write_single: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write pulse too long");
  a_write_allowed: assert property (reg_wr_en |-> reg_writable)
    else $error("write to unwritable place");
  a_cmd_single: assert property (cmd_start |=> !cmd_start)
    else $error("command pulse too long");
  a_irq_raise: assert property (cmd_done |=> irq)
    else $error("irq not raised");
  a_irq_clear: assert property (irq_ack && !cmd_done |=> !irq)
    else $error("irq not cleared");
endmodule : rsp_port_monitor

bind rsp_port rsp_port_monitor mon (
  .clk, .rst, .ss_n, .miso_oe_n, .miso_pulldown, .cfg, .reg_wr_en,
  .reg_writable, .fifo_push, .fifo_pop, .cmd_start, .cmd_done, .irq_ack,
  .irq
);

`default_nettype wire

/* File: bench/rsp_master.sv */
`default_nettype none

module rsp_master (
  // Serial pins
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n,
  input  wire logic miso_pulldown
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  logic line;
  ////////////////////////////////////////
  // released line: pulled low or not the last bit
  assign line = !miso_oe_n ? miso_out : (miso_pulldown ? 1'b0 : !last);
  always @(negedge sclk) if (!miso_oe_n) last <= miso_out;
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task sel;
    ss_n = 1'b0;
    #40;
  endtask : sel
  // release after the last edge, then stay high
  task desel;
    #300;
    ss_n = 1'b1;
    #150;
  endtask : desel
  // msb first; input taken at falling edge
  task xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      #10;
      mosi = tx[7 - i];
      #52.5;
      sclk = 1'b1;
      #62.5;
      rx = {rx[6:0], line};
      sclk = 1'b0;
    end
  endtask : xfer
endmodule : rsp_master

`default_nettype wire

/* File: bench/rsp_port_test.sv */
`default_nettype none

module rsp_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk, rst, sclk, ss_n, mosi;
  logic                 miso_out, miso_oe_n, miso_pulldown;
  rsp_pkg::rsp_cfg_t    cfg;
  rsp_pkg::rsp_reg_wr_t reg_wr;
  logic                 reg_wr_en, reg_writable, reg_rd_en, reg_rd_exists;
  logic [5:0]           reg_rd_addr, cmd_code_bits, last_cmd;
  logic [7:0]           reg_rd_data, fifo_push_data, fifo_head, rx;
  logic                 fifo_push, fifo_pop, cmd_start, cmd_done;
  logic                 irq_ack, irq, link_active;
  logic [7:0]           regs [64];
  logic [7:0]           tx [4];
  logic [7:0]           rxb [4];
  logic [7:0]           fq [$];
  int                   n_errors, compares;
  ////////////////////////////////////////
  rsp_port dut (
    .clk, .rst, .sclk, .ss_n, .mosi, .miso_out, .miso_oe_n, .miso_pulldown,
    .cfg, .reg_wr_en, .reg_wr, .reg_writable, .reg_rd_en, .reg_rd_addr,
    .reg_rd_data, .reg_rd_exists, .fifo_push, .fifo_push_data, .fifo_pop,
    .fifo_head, .cmd_start, .cmd_code_bits, .cmd_done, .irq_ack, .irq,
    .link_active
  );
  rsp_master m (.sclk, .ss_n, .mosi, .miso_out, .miso_oe_n, .miso_pulldown);
  // Top 4 writable places read-only, top 16 missing
  assign reg_writable = reg_wr.addr < 6'h2c;
  assign reg_rd_exists = reg_rd_addr < 6'h30;
  assign reg_rd_data = regs[reg_rd_addr];
  always @(negedge clk) begin
    if (reg_wr_en === 1'b1) regs[reg_wr.addr] = reg_wr.data;
    if (fifo_push === 1'b1) fq.push_back(fifo_push_data);
    if (fifo_pop === 1'b1) void'(fq.pop_front());
    if (cmd_start === 1'b1) last_cmd = cmd_code_bits;
    fifo_head = (fq.size() > 0) ? fq[0] : 8'h00;
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic op(input logic [7:0] hdr, input int n, input int lb);
    m.sel();
    m.xfer(hdr, 8, rx);
    for (int i = 0; i < n; i++) m.xfer(tx[i], (i == n - 1) ? lb : 8, rxb[i]);
    m.desel();
  endtask : op
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cfg = '0;
    cmd_done = 1'b0;
    irq_ack = 1'b0;
    for (int i = 0; i < 64; i++) regs[i] = 8'he7;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    tx = '{8'h81, 8'h3c, 8'hff, 8'h00};
    op(8'h2a, 3, 8);
    check(regs[6'h2a], 8'h81);
    check(regs[6'h2b], 8'h3c);
    check(regs[6'h2c], 8'he7);
    tx[0] = 8'hc3;
    op(8'h05, 1, 7);
    check(regs[6'h05], 8'he7);
    regs[6'h2e] = 8'h96;
    regs[6'h2f] = 8'h4b;
    op(8'h6e, 3, 8);
    check(rxb[0], 8'h96);
    check(rxb[1], 8'h4b);
    check(rxb[2], 8'h00);
    check({7'h0, miso_oe_n}, 8'h01);
    check({7'h0, link_active}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      cfg.miso_pulldown_opt_a = i[0];
      cfg.miso_pulldown_opt_b = i[1];
      @(negedge clk);
      check({7'h0, miso_pulldown}, {7'h0, i[0] | i[1]});
    end
    cfg.fifo_enable = 1'b1;
    cfg.osc_stable = 1'b1;
    tx = '{8'h11, 8'h22, 8'h5a, 8'h00};
    op(8'h80, 3, 5);
    check(8'(fq.size()), 8'h02);
    check(fq[0], 8'h11);
    @(negedge clk);
    cfg.osc_stable = 1'b0;
    op(8'h80, 1, 8);
    check(8'(fq.size()), 8'h02);
    @(negedge clk);
    cfg.osc_stable = 1'b1;
    op(8'hbf, 1, 4);
    check(8'(fq.size()), 8'h02);
    op(8'hbf, 2, 8);
    check(rxb[0], 8'h11);
    check(rxb[1], 8'h22);
    check(8'(fq.size()), 8'h00);
    op(8'h95, 1, 8);
    check(8'(fq.size()), 8'h00);
    m.sel();
    repeat (5) @(negedge clk);
    check({7'h0, link_active}, 8'h01);
    m.xfer(8'hd5, 8, rx);
    m.xfer(8'h01, 8, rx);
    m.xfer(8'h77, 8, rx);
    m.desel();
    check({2'h0, last_cmd}, 8'h15);
    check(regs[6'h01], 8'h77);
    // Nothing is sent until the long command reports back
    @(negedge clk);
    cmd_done = 1'b1;
    @(negedge clk);
    cmd_done = 1'b0;
    @(negedge clk);
    check({7'h0, irq}, 8'h01);
    irq_ack = 1'b1;
    @(negedge clk);
    irq_ack = 1'b0;
    @(negedge clk);
    check({7'h0, irq}, 8'h00);
    end_of_test();
  end
endmodule : rsp_port_test

`default_nettype wire
